/* File: hdl/cvt_int_check.sv */
`timescale 1ns/1ps
`default_nettype none
module cvt_int_check (
  input  wire logic [1:0]   fmt_i,
  input  wire logic [127:0] src_i,
  output logic              invalid_o,
  output logic [31:0]       sat_value_o
);

  logic above;
  logic at_limit;
  logic low_frac_nz;
  logic sign;

  // NaN and infinity have an all-ones exponent, so they land in "above"
  always_comb begin
    case (fmt_i)
      fp_policy_pkg::FMT_SINGLE: begin
        sign        = src_i[31];
        above       = src_i[30:23] > fp_policy_pkg::CVT_EXP_S;
        at_limit    = src_i[30:23] == fp_policy_pkg::CVT_EXP_S;
        low_frac_nz = |src_i[22:0];
      end
      fp_policy_pkg::FMT_DOUBLE: begin
        sign        = src_i[63];
        above       = src_i[62:52] > fp_policy_pkg::CVT_EXP_D;
        at_limit    = src_i[62:52] == fp_policy_pkg::CVT_EXP_D;
        low_frac_nz = |src_i[51:21];
      end
      default: begin
        sign        = src_i[127];
        above       = src_i[126:112] > fp_policy_pkg::CVT_EXP_Q;
        at_limit    = src_i[126:112] == fp_policy_pkg::CVT_EXP_Q;
        low_frac_nz = |src_i[111:81];
      end
    endcase
  end

  // Negative side tolerates magnitudes below 2^31 + 1
  assign invalid_o   = above | (at_limit & (~sign | low_frac_nz));
  assign sat_value_o = sign ? fp_policy_pkg::INT_NEG_SAT : fp_policy_pkg::INT_POS_SAT;

endmodule : cvt_int_check
`default_nettype wire

/* File: hdl/fp_exception_policy.sv */
// Design decisions made here: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Invalid without NaN input gives default NaN
// - Single quiet NaN input passes unchanged
// - Single signaling NaN: invalid, quieted input
// - Both quiet NaNs: return second source
// - Both signaling: invalid, quieted second source
// - One signaling NaN: invalid, return it quieted
// - One quiet NaN only: return it
// - Trapped underflow: tiny before rounding
// - Untrapped underflow needs tiny and inexact
// - Overflow judged on rounded result
// - Exact tiny traps only if subnormal, enabled
// - Tiny inexact: UF trap, NX trap, else flags
// - Underflow trap sets current flag only
// - Inexact trap sets current flag only
// - Integer conversion invalid outside signed range
// - Untrapped invalid conversion saturates by sign
// - Without flush option, mode bit reads zero
// - Flush subnormal operands, raise inexact
// - Flush subnormal results, raise underflow, inexact
// - Subnormals handled in hardware, no stall
// - Quieting keeps fraction, sets top bit
// - Trap keeps result, accrued; one current flag
module fp_exception_policy #(
  parameter bit NS_FLUSH_IMPL = 1'b1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [3:0]   reg_addr_i,
  input  wire logic [31:0]  reg_wdata_i,
  input  wire logic         reg_we_i,
  input  wire logic         reg_re_i,
  output logic [31:0]       reg_rdata_o,
  input  wire logic         op_valid_i,
  input  wire logic [1:0]   op_kind_i,
  input  wire logic [1:0]   op_fmt_i,
  input  wire logic [127:0] first_source_operand_i,
  input  wire logic [127:0] second_source_operand_i,
  input  wire logic [127:0] arith_result_i,
  input  wire logic [31:0]  arith_int_i,
  input  wire logic         arith_invalid_i,
  input  wire logic         arith_divzero_i,
  input  wire logic         arith_overflow_i,
  input  wire logic         arith_tiny_i,
  input  wire logic         arith_inexact_i,
  output logic              res_valid_o,
  output logic              res_write_o,
  output logic [127:0]      res_data_o,
  output logic [4:0]        cur_exc_o,
  output logic              trap_o
);

  localparam int W = fp_policy_pkg::EXC_W;

  logic [fp_policy_pkg::CTRL_W-1:0] ctrl_q;
  logic [W-1:0]                     cexc_q;
  logic [W-1:0]                     aexc_q;
  logic [W-1:0]                     trap_exc_q;
  logic                             trap_pend_q;
  logic                             res_valid_q;
  logic                             res_write_q;
  logic [127:0]                     res_data_q;
  logic                             trap_q;
  logic [31:0]                      rdata_q;

  logic                     ftz;
  logic                     two_src;
  logic                     is_cvt;
  fp_policy_pkg::fp_class_t c1;
  fp_policy_pkg::fp_class_t c2;
  fp_policy_pkg::fp_class_t cr;
  logic                     sub1;
  logic                     sub2;
  logic                     in_flushed;
  logic [127:0]             opnd1;
  logic [127:0]             opnd2;
  logic                     nan_hit;
  logic                     nan_invalid;
  logic [127:0]             nan_result;
  logic                     cvt_invalid;
  logic [31:0]              cvt_sat;
  logic                     res_sub;
  logic                     ftz_res;
  logic                     tiny;
  logic                     inexact_eff;
  logic [W-1:0]             raw_exc;
  logic [W-1:0]             trap_cand;
  logic [W-1:0]             trap_pick;
  logic                     trap_now;
  logic [127:0]             result;

  // Highest-priority enabled exception, as a one-hot vector
  function automatic logic [W-1:0] pick_one(input logic [W-1:0] v);
    logic [W-1:0] r;
    r = '0;
    if (v[fp_policy_pkg::EXC_NV]) begin
      r[fp_policy_pkg::EXC_NV] = 1'b1;
    end else if (v[fp_policy_pkg::EXC_OF]) begin
      r[fp_policy_pkg::EXC_OF] = 1'b1;
    end else if (v[fp_policy_pkg::EXC_UF]) begin
      r[fp_policy_pkg::EXC_UF] = 1'b1;
    end else if (v[fp_policy_pkg::EXC_DZ]) begin
      r[fp_policy_pkg::EXC_DZ] = 1'b1;
    end else if (v[fp_policy_pkg::EXC_NX]) begin
      r[fp_policy_pkg::EXC_NX] = 1'b1;
    end
    return r;
  endfunction : pick_one

  // Flush mode only exists when built in; otherwise the bit is held in ctrl_q but ignored
  assign ftz     = NS_FLUSH_IMPL & ctrl_q[fp_policy_pkg::CTRL_NS_BIT];
  assign two_src = op_kind_i == fp_policy_pkg::OP_TWO_SRC;
  assign is_cvt  = op_kind_i == fp_policy_pkg::OP_TO_INT;

  assign c1   = fp_policy_pkg::classify(op_fmt_i, first_source_operand_i);
  assign c2   = fp_policy_pkg::classify(op_fmt_i, second_source_operand_i);
  assign cr   = fp_policy_pkg::classify(op_fmt_i, arith_result_i);
  assign sub1 = two_src & fp_policy_pkg::is_subnormal(c1);
  assign sub2 = fp_policy_pkg::is_subnormal(c2);

  // Subnormal operands become signed zeros in one pass, no hold needed
  assign in_flushed = ftz & (sub1 | sub2);
  assign opnd1 = (ftz & sub1) ? fp_policy_pkg::to_zero(op_fmt_i, first_source_operand_i)
                              : first_source_operand_i;
  assign opnd2 = (ftz & sub2) ? fp_policy_pkg::to_zero(op_fmt_i, second_source_operand_i)
                              : second_source_operand_i;

  nan_select u_nan_select (
    .fmt_i         (op_fmt_i),
    .two_src_i     (two_src),
    .src1_i        (opnd1),
    .src2_i        (opnd2),
    .nan_hit_o     (nan_hit),
    .nan_invalid_o (nan_invalid),
    .nan_result_o  (nan_result)
  );

  cvt_int_check u_cvt_int_check (
    .fmt_i       (op_fmt_i),
    .src_i       (opnd2),
    .invalid_o   (cvt_invalid),
    .sat_value_o (cvt_sat)
  );

  // A flushed subnormal result is always an inexact tiny result
  assign res_sub     = fp_policy_pkg::is_subnormal(cr);
  assign ftz_res     = ftz & res_sub & ~is_cvt;
  assign inexact_eff = arith_inexact_i | ftz_res;
  assign tiny        = arith_tiny_i | ftz_res;

  always_comb begin
    raw_exc = '0;
    if (is_cvt) begin
      raw_exc[fp_policy_pkg::EXC_NV] = cvt_invalid;
      raw_exc[fp_policy_pkg::EXC_NX] = ~cvt_invalid & (arith_inexact_i | in_flushed);
    end else if (nan_hit) begin
      raw_exc[fp_policy_pkg::EXC_NV] = nan_invalid;
    end else if (arith_invalid_i) begin
      raw_exc[fp_policy_pkg::EXC_NV] = 1'b1;
    end else begin
      raw_exc[fp_policy_pkg::EXC_DZ] = arith_divzero_i;
      raw_exc[fp_policy_pkg::EXC_OF] = arith_overflow_i;
      // Exact tiny counts only as a trapped subnormal; inexact tiny always
      raw_exc[fp_policy_pkg::EXC_UF] = tiny & (inexact_eff |
          (ctrl_q[fp_policy_pkg::EXC_UF] & res_sub & ~ftz));
      raw_exc[fp_policy_pkg::EXC_NX] = inexact_eff |
          (in_flushed & ~arith_divzero_i & ~arith_overflow_i);
    end
  end

  // Untrapped underflow falls to the inexact trap when that is enabled
  assign trap_cand = raw_exc & ctrl_q[W-1:0];
  assign trap_pick = pick_one(trap_cand);
  assign trap_now  = |trap_cand;

  always_comb begin
    if (is_cvt) begin
      result = {96'h0, cvt_invalid ? cvt_sat : arith_int_i};
    end else if (nan_hit) begin
      result = nan_result;
    end else if (arith_invalid_i) begin
      result = fp_policy_pkg::default_qnan(op_fmt_i);
    end else if (ftz_res) begin
      result = fp_policy_pkg::to_zero(op_fmt_i, arith_result_i);
    end else begin
      result = arith_result_i & fp_policy_pkg::fmt_mask(op_fmt_i);
    end
  end

  // Control register: trap enables and the mode bit
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ctrl_q <= fp_policy_pkg::CTRL_RST;
    end else if (reg_we_i && reg_addr_i == fp_policy_pkg::REG_CTRL) begin
      ctrl_q <= reg_wdata_i[fp_policy_pkg::CTRL_W-1:0];
    end
  end

  // Current flags: a trap leaves exactly one bit, otherwise the raw set
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cexc_q <= fp_policy_pkg::EXC_RST;
    end else if (op_valid_i) begin
      cexc_q <= trap_now ? trap_pick : raw_exc;
    end else if (reg_we_i && reg_addr_i == fp_policy_pkg::REG_FLAGS) begin
      cexc_q <= reg_wdata_i[W-1:0];
    end
  end

  // Accrued flags: untouched by a trap; hardware set wins over a write
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      aexc_q <= fp_policy_pkg::EXC_RST;
    end else begin
      if (reg_we_i && reg_addr_i == fp_policy_pkg::REG_FLAGS) begin
        aexc_q <= reg_wdata_i[fp_policy_pkg::AEXC_LSB +: W] |
                  ((op_valid_i && !trap_now) ? raw_exc : '0);
      end else if (op_valid_i && !trap_now) begin
        aexc_q <= aexc_q | raw_exc;
      end
    end
  end

  // Last trap cause and a sticky pending bit, cleared by writing one
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      trap_exc_q  <= fp_policy_pkg::EXC_RST;
      trap_pend_q <= 1'b0;
    end else if (op_valid_i && trap_now) begin
      trap_exc_q  <= trap_pick;
      trap_pend_q <= 1'b1;
    end else if (reg_we_i && reg_addr_i == fp_policy_pkg::REG_TRAP &&
                 reg_wdata_i[fp_policy_pkg::TRAP_PEND_BIT]) begin
      trap_pend_q <= 1'b0;
    end
  end

  // Result stage: destination keeps its old value when a trap is taken
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      res_valid_q <= 1'b0;
      res_write_q <= 1'b0;
      trap_q      <= 1'b0;
      res_data_q  <= '0;
    end else begin
      res_valid_q <= op_valid_i;
      res_write_q <= op_valid_i & ~trap_now;
      trap_q      <= op_valid_i & trap_now;
      if (op_valid_i && !trap_now) begin
        res_data_q <= result;
      end
    end
  end

  // Read data stand for one cycle only
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rdata_q <= 32'h0;
    end else if (reg_re_i) begin
      case (reg_addr_i)
        fp_policy_pkg::REG_CTRL:
          rdata_q <= {26'h0, ftz, ctrl_q[W-1:0]};
        fp_policy_pkg::REG_FLAGS:
          rdata_q <= {19'h0, aexc_q, 3'h0, cexc_q};
        fp_policy_pkg::REG_TRAP:
          rdata_q <= {23'h0, trap_pend_q, 3'h0, trap_exc_q};
        default:
          rdata_q <= 32'h0;
      endcase
    end else begin
      rdata_q <= 32'h0;
    end
  end

  assign reg_rdata_o = rdata_q;
  assign res_valid_o = res_valid_q;
  assign res_write_o = res_write_q;
  assign res_data_o  = res_data_q;
  assign cur_exc_o   = cexc_q;
  assign trap_o      = trap_q;

endmodule : fp_exception_policy
`default_nettype wire

/* File: hdl/fp_policy_pkg.sv */
`default_nettype none
package fp_policy_pkg;

  // Operand formats; values sit right-justified in 128-bit words
  localparam logic [1:0] FMT_SINGLE = 2'h0;
  localparam logic [1:0] FMT_DOUBLE = 2'h1;
  localparam logic [1:0] FMT_QUAD   = 2'h2;

  // Operation classes issued by the integer unit
  localparam logic [1:0] OP_ONE_SRC = 2'h0;
  localparam logic [1:0] OP_TWO_SRC = 2'h1;
  localparam logic [1:0] OP_TO_INT  = 2'h2;

  // Exception flag positions, shared by flags and trap enables
  localparam int EXC_W  = 5;
  localparam int EXC_NX = 0;
  localparam int EXC_DZ = 1;
  localparam int EXC_UF = 2;
  localparam int EXC_OF = 3;
  localparam int EXC_NV = 4;

  localparam int CTRL_W      = 6;
  localparam int CTRL_NS_BIT = 5;
  localparam int AEXC_LSB    = 8;
  localparam int TRAP_PEND_BIT = 8;

  localparam logic [3:0] REG_CTRL  = 4'h0;
  localparam logic [3:0] REG_FLAGS = 4'h4;
  localparam logic [3:0] REG_TRAP  = 4'h8;

  localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;
  localparam logic [EXC_W-1:0]  EXC_RST  = 5'h00;

  localparam logic [31:0] INT_POS_SAT = 32'h7FFFFFFF;
  localparam logic [31:0] INT_NEG_SAT = 32'h80000000;

  // Biased exponent of 2^31 per format
  localparam logic [7:0]  CVT_EXP_S = 8'h9E;
  localparam logic [10:0] CVT_EXP_D = 11'h41E;
  localparam logic [14:0] CVT_EXP_Q = 15'h401E;

  typedef struct packed {
    logic sign;
    logic exp_ones;
    logic exp_zero;
    logic frac_zero;
    logic qbit;
  } fp_class_t;

  function automatic fp_class_t classify(input logic [1:0] fmt, input logic [127:0] x);
    fp_class_t c;
    c = '0;
    case (fmt)
      FMT_SINGLE: c = '{x[31], &x[30:23], ~|x[30:23], ~|x[22:0], x[22]};
      FMT_DOUBLE: c = '{x[63], &x[62:52], ~|x[62:52], ~|x[51:0], x[51]};
      default:    c = '{x[127], &x[126:112], ~|x[126:112], ~|x[111:0], x[111]};
    endcase
    return c;
  endfunction : classify

  function automatic logic is_nan(input fp_class_t c);
    return c.exp_ones & ~c.frac_zero;
  endfunction : is_nan

  function automatic logic is_snan(input fp_class_t c);
    return c.exp_ones & ~c.frac_zero & ~c.qbit;
  endfunction : is_snan

  function automatic logic is_subnormal(input fp_class_t c);
    return c.exp_zero & ~c.frac_zero;
  endfunction : is_subnormal

  function automatic logic [127:0] fmt_mask(input logic [1:0] fmt);
    case (fmt)
      FMT_SINGLE: return 128'h0000_0000_0000_0000_0000_0000_FFFF_FFFF;
      FMT_DOUBLE: return 128'h0000_0000_0000_0000_FFFF_FFFF_FFFF_FFFF;
      default:    return 128'hFFFF_FFFF_FFFF_FFFF_FFFF_FFFF_FFFF_FFFF;
    endcase
  endfunction : fmt_mask

  // Same-format quieting keeps every fraction bit and sets the top one
  function automatic logic [127:0] quiet(input logic [1:0] fmt, input logic [127:0] x);
    logic [127:0] qb;
    case (fmt)
      FMT_SINGLE: qb = 128'h0000_0000_0000_0000_0000_0000_0040_0000;
      FMT_DOUBLE: qb = 128'h0000_0000_0000_0000_0008_0000_0000_0000;
      default:    qb = 128'h0000_8000_0000_0000_0000_0000_0000_0000;
    endcase
    return (x | qb) & fmt_mask(fmt);
  endfunction : quiet

  function automatic logic [127:0] to_zero(input logic [1:0] fmt, input logic [127:0] x);
    case (fmt)
      FMT_SINGLE: return x & 128'h0000_0000_0000_0000_0000_0000_8000_0000;
      FMT_DOUBLE: return x & 128'h0000_0000_0000_0000_8000_0000_0000_0000;
      default:    return x & 128'h8000_0000_0000_0000_0000_0000_0000_0000;
    endcase
  endfunction : to_zero

  function automatic logic [127:0] default_qnan(input logic [1:0] fmt);
    case (fmt)
      FMT_SINGLE: return 128'h0000_0000_0000_0000_0000_0000_7FFF_FFFF;
      FMT_DOUBLE: return 128'h0000_0000_0000_0000_7FFF_FFFF_FFFF_FFFF;
      default:    return 128'h7FFF_FFFF_FFFF_FFFF_FFFF_FFFF_FFFF_FFFF;
    endcase
  endfunction : default_qnan

endpackage : fp_policy_pkg
`default_nettype wire

/* File: hdl/nan_select.sv */
`timescale 1ns/1ps
`default_nettype none
module nan_select (
  input  wire logic [1:0]   fmt_i,
  input  wire logic         two_src_i,
  input  wire logic [127:0] src1_i,
  input  wire logic [127:0] src2_i,
  output logic              nan_hit_o,
  output logic              nan_invalid_o,
  output logic [127:0]      nan_result_o
);

  fp_policy_pkg::fp_class_t c1;
  fp_policy_pkg::fp_class_t c2;
  logic s1;
  logic s2;
  logic q1;
  logic q2;

  // A single-source operation carries its operand in the second source
  assign c1 = fp_policy_pkg::classify(fmt_i, src1_i);
  assign c2 = fp_policy_pkg::classify(fmt_i, src2_i);
  assign s1 = two_src_i & fp_policy_pkg::is_snan(c1);
  assign s2 = fp_policy_pkg::is_snan(c2);
  assign q1 = two_src_i & fp_policy_pkg::is_nan(c1) & c1.qbit;
  assign q2 = fp_policy_pkg::is_nan(c2) & c2.qbit;

  always_comb begin
    nan_hit_o     = 1'b1;
    nan_invalid_o = 1'b0;
    nan_result_o  = '0;
    if (s2) begin
      nan_invalid_o = 1'b1;
      nan_result_o  = fp_policy_pkg::quiet(fmt_i, src2_i);
    end else if (s1) begin
      nan_invalid_o = 1'b1;
      nan_result_o  = fp_policy_pkg::quiet(fmt_i, src1_i);
    end else if (q2) begin
      nan_result_o  = src2_i & fp_policy_pkg::fmt_mask(fmt_i);
    end else if (q1) begin
      nan_result_o  = src1_i & fp_policy_pkg::fmt_mask(fmt_i);
    end else begin
      nan_hit_o     = 1'b0;
    end
  end

endmodule : nan_select
`default_nettype wire

/* File: verification/fp_policy_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module fp_policy_chk #(
  parameter bit NS_FLUSH_IMPL = 1'b1
) (
  input wire logic         clk_i,
  input wire logic         rst_n_i,
  input wire logic [3:0]   reg_addr_i,
  input wire logic [31:0]  reg_wdata_i,
  input wire logic         reg_we_i,
  input wire logic         reg_re_i,
  input wire logic [31:0]  reg_rdata_o,
  input wire logic         op_valid_i,
  input wire logic [1:0]   op_kind_i,
  input wire logic [1:0]   op_fmt_i,
  input wire logic [127:0] first_source_operand_i,
  input wire logic [127:0] second_source_operand_i,
  input wire logic [127:0] arith_result_i,
  input wire logic [31:0]  arith_int_i,
  input wire logic         arith_invalid_i,
  input wire logic         arith_divzero_i,
  input wire logic         arith_overflow_i,
  input wire logic         arith_tiny_i,
  input wire logic         arith_inexact_i,
  input wire logic         res_valid_o,
  input wire logic         res_write_o,
  input wire logic [127:0] res_data_o,
  input wire logic [4:0]   cur_exc_o,
  input wire logic         trap_o
);
  // NaN, convert and flag checks single format only; the bench drives NaN cases in all three formats and conversion from double
  wire logic [31:0] s1  = first_source_operand_i[31:0], s2 = second_source_operand_i[31:0];
  wire logic        sel = op_valid_i && op_fmt_i == fp_policy_pkg::FMT_SINGLE;
  wire logic        one = sel && op_kind_i == fp_policy_pkg::OP_ONE_SRC;
  wire logic        two = sel && op_kind_i == fp_policy_pkg::OP_TWO_SRC;
  wire logic        cvt = sel && op_kind_i == fp_policy_pkg::OP_TO_INT;
  wire logic        num = !(&s1[30:23]) && !(&s2[30:23]);
  wire logic        qn2 = &s2[30:22];
  wire logic        sn2 = &s2[30:23] && !s2[22] && |s2[21:0];
  wire logic        nv  = cur_exc_o[fp_policy_pkg::EXC_NV];
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_lat; op_valid_i |=> res_valid_o; endproperty
  a_lat: assert property (p_lat) else $error("result missing after op");
  property p_idle; !op_valid_i |=> !res_valid_o && !trap_o; endproperty
  a_idle: assert property (p_idle) else $error("result without op");
  property p_trap;
    (trap_o || res_write_o) |-> res_valid_o && trap_o != res_write_o
      && (!trap_o || $onehot(cur_exc_o));
  endproperty
  a_trap: assert property (p_trap) else $error("trap outcome wrong");
  property p_hold; res_valid_o && !res_write_o |-> $stable(res_data_o); endproperty
  a_hold: assert property (p_hold) else $error("result changed on trap");
  property p_qpass; one && qn2 |=> cur_exc_o == 5'h00 && res_data_o[31:0] == $past(s2); endproperty
  a_qpass: assert property (p_qpass) else $error("quiet NaN not passed");
  property p_squiet;
    (one || two) && sn2 |=> nv && (!res_write_o || res_data_o[31:0] == ($past(s2) | 32'h00400000));
  endproperty
  a_squiet: assert property (p_squiet) else $error("signaling NaN not quieted");
  property p_dnan;
    two && num && arith_invalid_i |=> nv && (!res_write_o || res_data_o[31:0] == 32'h7FFF_FFFF);
  endproperty
  a_dnan: assert property (p_dnan) else $error("default NaN wrong");
  property p_cvt;
    cvt && !s2[31] && s2[30:23] >= fp_policy_pkg::CVT_EXP_S |=> nv
      && (!res_write_o || res_data_o[31:0] == fp_policy_pkg::INT_POS_SAT);
  endproperty
  a_cvt: assert property (p_cvt) else $error("conversion not saturated");
  property p_of; two && num && arith_overflow_i |=> nv || cur_exc_o[fp_policy_pkg::EXC_OF]
    || (trap_o && cur_exc_o == 5'h01); endproperty
  a_of: assert property (p_of) else $error("overflow not flagged");
  property p_uf;
    two && num && arith_tiny_i && arith_inexact_i && !arith_invalid_i && !arith_overflow_i
      && !arith_divzero_i |=> cur_exc_o[fp_policy_pkg::EXC_UF] || cur_exc_o[fp_policy_pkg::EXC_NX];
  endproperty
  a_uf: assert property (p_uf) else $error("tiny inexact not flagged");
  c_trap: cover property (trap_o);
  c_b2b: cover property (res_valid_o ##1 res_valid_o);
  c_cvt: cover property (cvt);
endmodule : fp_policy_chk
bind fp_exception_policy fp_policy_chk #(.NS_FLUSH_IMPL(NS_FLUSH_IMPL)) i_chk (.*);
`default_nettype wire

/* File: verification/iu_model.sv */
`timescale 1ns/1ps
`default_nettype none
module iu_model (
  input  wire logic    clk_i,
  output logic         op_valid_o,
  output logic [1:0]   op_kind_o,
  output logic [1:0]   op_fmt_o,
  output logic [127:0] src1_o,
  output logic [127:0] src2_o,
  output logic [127:0] ares_o,
  output logic [31:0]  aint_o,
  output logic [4:0]   aflags_o
);
  initial begin
    {op_valid_o, op_kind_o, op_fmt_o, src1_o, src2_o, ares_o, aint_o, aflags_o} = '0;
  end
  // Idle of 0 lets the next call follow with no gap
  task automatic issue(input logic [1:0] k, f, input logic [127:0] a, b, r,
                       input logic [4:0] fl, input bit idle);
    @(posedge clk_i);
    op_valid_o <= 1'h1;
    op_kind_o  <= k;
    op_fmt_o   <= f;
    src1_o     <= a;
    src2_o     <= b;
    ares_o     <= r;
    aint_o     <= r[31:0];
    aflags_o   <= fl;
    if (idle) begin
      @(posedge clk_i);
      op_valid_o <= 1'h0;
      // Inverted so a missed strobe cannot pass on stale data
      src1_o     <= ~a;
      src2_o     <= ~b;
      aflags_o   <= ~fl;
    end
  endtask : issue
endmodule : iu_model
`default_nettype wire

/* File: verification/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam logic [1:0] K1 = fp_policy_pkg::OP_ONE_SRC;
  localparam logic [1:0] K2 = fp_policy_pkg::OP_TWO_SRC;
  localparam logic [1:0] KC = fp_policy_pkg::OP_TO_INT;
  logic         clk_i, rst_n_i, reg_we_i, reg_re_i, op_valid, res_valid_o, res_write_o, trap_o, s;
  logic [3:0]   reg_addr_i;
  logic [31:0]  reg_wdata_i, reg_rdata_o;
  logic [1:0]   op_kind, op_fmt;
  logic [127:0] src1, src2, ares, res_data_o, last, msk, q, ex, qn1, qn2, sn1, sn2, r, b;
  logic [31:0]  aint;
  logic [4:0]   aflags, cur_exc_o;
  logic [134:0] exp_q[$];
  logic [134:0] e;
  int           bad_count, n_tests, seed, w;
  logic [5:0]   tbl[3][4] = '{'{6'h24, 6'h24, 6'h00, 6'h09}, '{6'h21, 6'h00, 6'h00, 6'h21},
                              '{6'h05, 6'h00, 6'h00, 6'h09}};
  logic [127:0] uv[4] = '{128'h0080_0000, 128'h1, 128'h8000_0000, 128'h7F80_0000};
  logic [4:0]   ufl[4] = '{5'h03, 5'h02, 5'h02, 5'h05};
  logic [31:0]  cv[3] = '{32'h04, 32'h01, 32'h00}, fv[3] = '{32'h0909, 32'h0901, 32'h0D09};
  logic [63:0]  cb[9] = '{64'h4F00_0000, 64'hCF00_0000, 64'hCF00_0001, 64'h4EFF_FFFF,
                          64'h7FC0_0000, 64'hFF80_0000, 64'h41E0_0000_0000_0000,
                          64'hC1E0_0000_0010_0000, 64'hC1E0_0000_0020_0000};
  logic [8:0]   cinv = 9'h175;
  iu_model i_iu (.clk_i(clk_i), .op_valid_o(op_valid), .op_kind_o(op_kind), .op_fmt_o(op_fmt),
    .src1_o(src1), .src2_o(src2), .ares_o(ares), .aint_o(aint), .aflags_o(aflags));
  fp_exception_policy #(.NS_FLUSH_IMPL(1'b1)) i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i),
    .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o), .op_valid_i(op_valid), .op_kind_i(op_kind),
    .op_fmt_i(op_fmt), .first_source_operand_i(src1), .second_source_operand_i(src2),
    .arith_result_i(ares), .arith_int_i(aint), .arith_invalid_i(aflags[4]),
    .arith_divzero_i(aflags[3]), .arith_overflow_i(aflags[2]), .arith_tiny_i(aflags[1]),
    .arith_inexact_i(aflags[0]), .res_valid_o(res_valid_o), .res_write_o(res_write_o),
    .res_data_o(res_data_o), .cur_exc_o(cur_exc_o), .trap_o(trap_o));
  initial begin
    clk_i = 1'h0;
    forever #12.5 clk_i = ~clk_i;
  end
  task automatic chk(input logic [134:0] seen, input logic [134:0] want);
    n_tests++;
    if (seen !== want) begin
      bad_count++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, want);
    end
  endtask : chk
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : give_verdict
  function automatic logic [127:0] rnd();
    return {$random(seed), $random(seed), $random(seed), $random(seed)};
  endfunction : rnd
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_we_i    <= 1'h1;
    @(posedge clk_i);
    reg_we_i    <= 1'h0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] want);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_re_i   <= 1'h1;
    @(posedge clk_i);
    reg_re_i   <= 1'h0;
    #1 chk(reg_rdata_o, want);
  endtask : rd
  // Trapped ops keep the old destination
  task automatic op(input logic [1:0] k, f, input logic [127:0] a, b, r, input logic [4:0] fl,
                    input logic [127:0] d, input logic [5:0] ex, input bit idle);
    exp_q.push_back({!ex[5], ex[5], ex[4:0], ex[5] ? last : d});
    if (!ex[5]) last = d;
    i_iu.issue(k, f, a, b, r, fl, idle);
  endtask : op
  always @(negedge clk_i) begin
    if (res_valid_o !== 1'h0) begin
      e = exp_q.size() > 0 ? exp_q.pop_front() : 'x;
      chk({res_write_o, trap_o, cur_exc_o, res_data_o}, e);
    end
  end
  initial begin
    seed = 17;
    {rst_n_i, reg_we_i, reg_re_i, reg_addr_i, reg_wdata_i, last} = '0;
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'h1;
    for (int i = 0; i < 4; i++) rd(4'(i * 4), 32'h0);
    $display("test reset done");
    for (int f = 0; f < 3; f++) begin
      w = f == 0 ? 32 : f == 1 ? 64 : 128;
      msk = w == 128 ? '1 : (128'h1 << w) - 128'h1;
      q = 128'h1 << (w == 32 ? 22 : w == 64 ? 51 : 111);
      ex = (msk >> 1) & ~((q << 1) - 128'h1);
      qn1 = (rnd() & msk) | ex | q;
      qn2 = (rnd() & msk) | ex | q;
      sn1 = ((rnd() & msk) | ex | 128'h1) & ~q;
      sn2 = ((rnd() & msk) | ex | 128'h1) & ~q;
      r = rnd();
      op(K1, 2'(f), sn1, qn2, r, 5'h00, qn2, 6'h00, 0);
      op(K1, 2'(f), qn1, sn2, r, 5'h00, sn2 | q, 6'h10, 0);
      op(K2, 2'(f), qn1, qn2, r, 5'h00, qn2, 6'h00, 0);
      op(K2, 2'(f), sn1, sn2, r, 5'h00, sn2 | q, 6'h10, 0);
      op(K2, 2'(f), sn1, qn2, r, 5'h00, sn1 | q, 6'h10, 0);
      op(K2, 2'(f), '0, sn2, r, 5'h00, sn2 | q, 6'h10, 0);
      op(K2, 2'(f), qn1, '0, r, 5'h00, qn1, 6'h00, 0);
      op(K2, 2'(f), '0, '0, r, 5'h10, msk >> 1, 6'h10, 1);
    end
    $display("test nan done");
    wr(4'h4, 32'h0);
    for (int c = 0; c < 3; c++) begin
      wr(4'h0, cv[c]);
      for (int j = 0; j < 4; j++)
        op(K2, 2'h0, '0, '0, uv[j], ufl[j], uv[j], tbl[c][j], j == 3);
      rd(4'h4, fv[c]);
    end
    rd(4'h8, 32'h0000_0101);
    $display("test underflow done");
    for (int i = 0; i < 9; i++) begin
      r = {96'h0, 32'($random(seed))};
      b = {64'h0, cb[i]};
      s = i > 5 ? b[63] : b[31];
      op(KC, i > 5 ? 2'h1 : 2'h0, rnd(), b, r, 5'h00, cinv[i] ? (s ? 128'h8000_0000 :
         128'h7FFF_FFFF) : r, cinv[i] ? 6'h10 : 6'h00, i == 8);
    end
    $display("test convert done");
    wr(4'hC, 32'hFFFF_FFFF);
    wr(4'h0, 32'h20);
    rd(4'h0, 32'h20);
    r = 128'h3F80_0000;
    op(K2, 2'h0, 128'h1, r, r, 5'h00, r, 6'h01, 0);
    op(K2, 2'h0, '0, '0, 128'h8000_0001, 5'h02, 128'h8000_0000, 6'h05, 1);
    wr(4'h0, 32'h21);
    op(K2, 2'h0, r, 128'h3, r, 5'h00, r, 6'h21, 1);
    $display("test flush done");
    repeat (3) @(posedge clk_i);
    chk(135'(exp_q.size()), 135'h0);
    give_verdict();
  end
  initial begin
    repeat (3000) @(posedge clk_i);
    bad_count++;
    $display("mismatch at %0t: run did not finish", $time);
    give_verdict();
  end
endmodule : tb
`default_nettype wire
